/* design/pes_pkg.sv */
package pes_pkg;

    // Event select and unit mask codes.
    localparam logic [7:0] EV_L2_REQ = 8'h24;
    localparam logic [7:0] EV_OWN_REQ = 8'h27;
    localparam logic [7:0] EV_L1_WB = 8'h28;
    localparam logic [7:0] EV_LLC = 8'h2e;
    localparam logic [7:0] EV_UNHALTED = 8'h3c;
    localparam logic [7:0] EV_L1_PEND = 8'h48;
    localparam logic [7:0] EV_ST_TLB = 8'h49;

    localparam logic [7:0] UM_CODE_HIT = 8'h10;
    localparam logic [7:0] UM_CODE_MISS = 8'h20;
    localparam logic [7:0] UM_CODE_ANY = 8'h30;
    localparam logic [7:0] UM_PF_HIT = 8'h40;
    localparam logic [7:0] UM_PF_MISS = 8'h80;
    localparam logic [7:0] UM_PF_ANY = 8'hc0;
    localparam logic [7:0] UM_00 = 8'h00;
    localparam logic [7:0] UM_01 = 8'h01;
    localparam logic [7:0] UM_02 = 8'h02;
    localparam logic [7:0] UM_04 = 8'h04;
    localparam logic [7:0] UM_08 = 8'h08;
    localparam logic [7:0] UM_0F = 8'h0f;
    localparam logic [7:0] UM_LLC_MISS = 8'h41;
    localparam logic [7:0] UM_LLC_REF = 8'h4f;

    // Register byte offsets.
    localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
    localparam logic [31:0] OFS_COUNT = 32'h0000_0004;
    localparam logic [31:0] OFS_STATUS = 32'h0000_0008;

    // Control register field positions.
    localparam int CTRL_EVSEL_LSB = 0;
    localparam int CTRL_UMASK_LSB = 8;
    localparam int CTRL_EDGE_BIT = 18;
    localparam int CTRL_EN_BIT = 22;
    localparam int CTRL_CMASK_LSB = 24;
    // Status register field positions.
    localparam int STAT_KNOWN_BIT = 0;
    localparam int STAT_COND_BIT = 1;
    localparam int STAT_AMT_LSB = 8;

    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_COUNT = 32'h0000_0000;

    // Reference tick: main clock rate over reference rate, in MHz.
    localparam int CORE_CLK_MHZ = 100;
    localparam int REF_CLK_MHZ = 100;
    localparam int REF_DIV_CYC = (CORE_CLK_MHZ + REF_CLK_MHZ - 1) / REF_CLK_MHZ;
    localparam logic [7:0] REF_DIV_LAST = 8'(REF_DIV_CYC - 1);

    typedef struct packed {
        logic l2_code_fetch_hit;
        logic l2_code_fetch_miss;
        logic l2_prefetch_hit;
        logic l2_prefetch_miss;
        logic store_own_req_miss;
        logic store_own_req_hit_e;
        logic store_own_req_hit_m;
        logic wb_miss;
        logic wb_hit_s;
        logic wb_hit_e;
        logic wb_hit_m;
        logic last_level_ref;
        logic last_level_miss;
        logic thread_halted;
        logic [3:0] outstanding_l1_misses;
        logic store_walk_start;
        logic store_walk_done;
        logic page_miss_handler_store_busy;
    } pes_events_t;

    typedef struct packed {
        logic known;
        logic [3:0] amt;
    } pes_dec_t;

    typedef struct packed {
        logic [7:0] evsel;
        logic [7:0] umask;
        logic edge_det;
        logic enable;
        logic [7:0] cmask;
        logic [31:0] count;
        logic cond;
        logic wr_pend;
        logic [1:0] wr_idx;
        logic wr_ok;
        logic [31:0] rdata;
    } pes_state_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } pes_tick_state_t;

endpackage : pes_pkg

/* design/pes_ref_tick.sv */
`timescale 1ns/1ps
`default_nettype none

// One-cycle enable at the reference rate, derived from the main clock.
module pes_ref_tick (
    input wire logic core_clk,
    input wire logic rst,
    output logic tick
);
    import pes_pkg::*;

    pes_tick_state_t s_q;
    pes_tick_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = (s_q.cnt == REF_DIV_LAST);
        if (s_q.cnt == REF_DIV_LAST) begin
            s_d.cnt = 8'h00;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule : pes_ref_tick

`default_nettype wire

/* design/pes_decoder.sv */
// What this block does
// - 24H code: 10H hit, 20H miss, 30H all.
// - 24H prefetches: 40H hit, 80H miss.
// - 24H C0H counts every prefetcher request.
// - 27H ownership: 01H miss, 04H exclusive, 08H modified.
// - 27H 0FH counts ownership requests, any state.
// - 28H writebacks: 01H miss, 02H/04H/08H S/E/M hits.
// - 28H 0FH counts every accepted writeback.
// - 2EH 4FH counts last-level references.
// - 2EH 41H counts last-level misses.
// - 3CH 00H counts unhalted thread cycles.
// - 3CH 01H counts reference ticks while unhalted.
// - 48H 01H adds outstanding first-level misses.
// - Threshold 1 with edge counts rises.
// - 49H 01H counts store walks started.
// - 49H 02H counts store walks completed.
// - 49H 04H counts handler busy cycles.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pes_decoder (
    input wire logic core_clk,
    input wire logic rst,
    input wire pes_pkg::pes_events_t ev,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    import pes_pkg::*;

    pes_state_t s_q;
    pes_state_t s_d;
    pes_dec_t dec;
    logic ref_tick;
    logic [3:0] inc;
    logic accept;

    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_COUNT = 2'h1;
    localparam logic [1:0] IDX_STATUS = 2'h2;

    function automatic logic [3:0] b2a(input logic b);
        b2a = {3'h0, b};
    endfunction : b2a

    // Maps a byte address to a register index; also reports whether it is mapped.
    function automatic logic [2:0] reg_idx(input logic [31:0] a);
        logic ok;
        ok = 1'b0;
        if (a == OFS_CTRL) begin
            reg_idx = {1'b1, IDX_CTRL};
        end else if (a == OFS_COUNT) begin
            reg_idx = {1'b1, IDX_COUNT};
        end else if (a == OFS_STATUS) begin
            reg_idx = {1'b1, IDX_STATUS};
        end else begin
            reg_idx = {ok, 2'h3};
        end
    endfunction : reg_idx

    function automatic pes_dec_t decode(
        input logic [7:0] es,
        input logic [7:0] um,
        input pes_events_t e,
        input logic tick
    );
        pes_dec_t r;
        r.known = 1'b1;
        r.amt = 4'h0;
        case (es)
            EV_L2_REQ: begin
                case (um)
                    UM_CODE_HIT: r.amt = b2a(e.l2_code_fetch_hit);
                    UM_CODE_MISS: r.amt = b2a(e.l2_code_fetch_miss);
                    UM_CODE_ANY: begin
                        r.amt = b2a(e.l2_code_fetch_hit) + b2a(e.l2_code_fetch_miss);
                    end
                    UM_PF_HIT: r.amt = b2a(e.l2_prefetch_hit);
                    UM_PF_MISS: r.amt = b2a(e.l2_prefetch_miss);
                    UM_PF_ANY: begin
                        r.amt = b2a(e.l2_prefetch_hit) + b2a(e.l2_prefetch_miss);
                    end
                    default: r.known = 1'b0;
                endcase
            end
            EV_OWN_REQ: begin
                case (um)
                    UM_01: r.amt = b2a(e.store_own_req_miss);
                    UM_04: r.amt = b2a(e.store_own_req_hit_e);
                    UM_08: r.amt = b2a(e.store_own_req_hit_m);
                    UM_0F: begin
                        r.amt = b2a(e.store_own_req_miss) + b2a(e.store_own_req_hit_e)
                            + b2a(e.store_own_req_hit_m);
                    end
                    default: r.known = 1'b0;
                endcase
            end
            EV_L1_WB: begin
                case (um)
                    UM_01: r.amt = b2a(e.wb_miss);
                    UM_02: r.amt = b2a(e.wb_hit_s);
                    UM_04: r.amt = b2a(e.wb_hit_e);
                    UM_08: r.amt = b2a(e.wb_hit_m);
                    UM_0F: begin
                        r.amt = b2a(e.wb_miss) + b2a(e.wb_hit_s) + b2a(e.wb_hit_e)
                            + b2a(e.wb_hit_m);
                    end
                    default: r.known = 1'b0;
                endcase
            end
            EV_LLC: begin
                case (um)
                    UM_LLC_REF: r.amt = b2a(e.last_level_ref);
                    UM_LLC_MISS: r.amt = b2a(e.last_level_miss);
                    default: r.known = 1'b0;
                endcase
            end
            EV_UNHALTED: begin
                case (um)
                    UM_00: r.amt = b2a(!e.thread_halted);
                    UM_01: r.amt = b2a(tick && !e.thread_halted);
                    default: r.known = 1'b0;
                endcase
            end
            EV_L1_PEND: begin
                case (um)
                    UM_01: r.amt = e.outstanding_l1_misses;
                    default: r.known = 1'b0;
                endcase
            end
            EV_ST_TLB: begin
                case (um)
                    UM_01: r.amt = b2a(e.store_walk_start);
                    UM_02: r.amt = b2a(e.store_walk_done);
                    UM_04: r.amt = b2a(e.page_miss_handler_store_busy);
                    default: r.known = 1'b0;
                endcase
            end
            default: r.known = 1'b0;
        endcase
        if (!r.known) begin
            r.amt = 4'h0;
        end
        decode = r;
    endfunction : decode

    // The reference tick is an enable, so the counter stays in the one clock domain.
    pes_ref_tick u_ref_tick (
        .core_clk(core_clk),
        .rst(rst),
        .tick(ref_tick)
    );

    assign dec = decode(s_q.evsel, s_q.umask, ev, ref_tick);
    assign accept = hsel && htrans[1] && hready;

    always_comb begin
        logic thr;
        logic [2:0] ri;
        thr = 1'b0;
        ri = 3'h0;
        s_d = s_q;
        inc = dec.amt;
        // A nonzero threshold turns the amount into a yes/no condition per cycle.
        if (s_q.cmask != 8'h00) begin
            thr = ({4'h0, dec.amt} >= s_q.cmask);
            s_d.cond = thr;
            if (s_q.edge_det) begin
                inc = b2a(thr && !s_q.cond);
            end else begin
                inc = b2a(thr);
            end
        end else begin
            s_d.cond = 1'b0;
        end
        if (!s_q.enable) begin
            inc = 4'h0;
        end
        // A software write to the counter wins over the same cycle's increment.
        if (s_q.wr_pend && s_q.wr_ok && s_q.wr_idx == IDX_COUNT) begin
            s_d.count = hwdata;
        end else begin
            s_d.count = s_q.count + {28'h0, inc};
        end
        if (s_q.wr_pend && s_q.wr_ok && s_q.wr_idx == IDX_CTRL) begin
            s_d.evsel = hwdata[CTRL_EVSEL_LSB +: 8];
            s_d.umask = hwdata[CTRL_UMASK_LSB +: 8];
            s_d.edge_det = hwdata[CTRL_EDGE_BIT];
            s_d.enable = hwdata[CTRL_EN_BIT];
            s_d.cmask = hwdata[CTRL_CMASK_LSB +: 8];
        end
        s_d.wr_pend = accept && hwrite;
        if (accept) begin
            ri = reg_idx(haddr);
            s_d.wr_idx = ri[1:0];
            s_d.wr_ok = ri[2];
        end
        // Control and count read data are taken from the next state so a read right after a write sees it; status uses the current decode.
        if (accept && !hwrite) begin
            ri = reg_idx(haddr);
            s_d.rdata = 32'h0000_0000;
            if (ri[2]) begin
                case (ri[1:0])
                    IDX_CTRL: begin
                        s_d.rdata[CTRL_EVSEL_LSB +: 8] = s_d.evsel;
                        s_d.rdata[CTRL_UMASK_LSB +: 8] = s_d.umask;
                        s_d.rdata[CTRL_EDGE_BIT] = s_d.edge_det;
                        s_d.rdata[CTRL_EN_BIT] = s_d.enable;
                        s_d.rdata[CTRL_CMASK_LSB +: 8] = s_d.cmask;
                    end
                    IDX_COUNT: s_d.rdata = s_d.count;
                    IDX_STATUS: begin
                        s_d.rdata[STAT_KNOWN_BIT] = dec.known;
                        s_d.rdata[STAT_COND_BIT] = s_q.cond;
                        s_d.rdata[STAT_AMT_LSB +: 4] = dec.amt;
                    end
                    default: s_d.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.evsel <= RST_CTRL[CTRL_EVSEL_LSB +: 8];
            s_q.umask <= RST_CTRL[CTRL_UMASK_LSB +: 8];
            s_q.cmask <= RST_CTRL[CTRL_CMASK_LSB +: 8];
            s_q.count <= RST_COUNT;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata = s_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Checks on the decoder; plain means enabled with no threshold or edge.
    logic plain;
    logic nowr;
    assign plain = s_q.enable && s_q.cmask == 8'h00 && !s_q.edge_det;
    assign nowr = !(s_q.wr_pend && s_q.wr_ok && s_q.wr_idx == IDX_COUNT);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    code_fetch_a:
    assert property (plain && s_q.evsel == EV_L2_REQ && s_q.umask == UM_CODE_ANY
        |-> inc == b2a(ev.l2_code_fetch_hit) + b2a(ev.l2_code_fetch_miss))
        else $error("code fetch count wrong");
    prefetch_hit_a:
    assert property (plain && s_q.evsel == EV_L2_REQ && s_q.umask == UM_PF_HIT && nowr
        |=> s_q.count == $past(s_q.count) + b2a($past(ev.l2_prefetch_hit)))
        else $error("prefetch hit count wrong");
    prefetch_any_a:
    assert property (plain && s_q.evsel == EV_L2_REQ && s_q.umask == UM_PF_ANY
        && ev.l2_prefetch_hit && ev.l2_prefetch_miss |-> inc == 4'h2)
        else $error("prefetch any count wrong");
    own_exclusive_a:
    assert property (plain && s_q.evsel == EV_OWN_REQ && s_q.umask == UM_04
        |-> inc == b2a(ev.store_own_req_hit_e))
        else $error("ownership exclusive count wrong");
    own_any_a:
    assert property (plain && s_q.evsel == EV_OWN_REQ && s_q.umask == UM_0F
        && ev.store_own_req_miss && ev.store_own_req_hit_m |-> inc >= 4'h2)
        else $error("ownership any count wrong");
    wb_shared_a:
    assert property (plain && s_q.evsel == EV_L1_WB && s_q.umask == UM_02
        |-> inc == b2a(ev.wb_hit_s))
        else $error("writeback shared count wrong");
    wb_any_a:
    assert property (plain && s_q.evsel == EV_L1_WB && s_q.umask == UM_0F
        |-> inc == b2a(ev.wb_miss) + b2a(ev.wb_hit_s) + b2a(ev.wb_hit_e) + b2a(ev.wb_hit_m))
        else $error("writeback any count wrong");
    llc_ref_a:
    assert property (plain && s_q.evsel == EV_LLC && s_q.umask == UM_LLC_REF
        |-> inc == b2a(ev.last_level_ref))
        else $error("last level reference count wrong");
    llc_miss_a:
    assert property (plain && s_q.evsel == EV_LLC && s_q.umask == UM_LLC_MISS && nowr
        && ev.last_level_miss |=> s_q.count == $past(s_q.count) + 32'h1)
        else $error("last level miss count wrong");
    halted_hold_a:
    assert property (plain && s_q.evsel == EV_UNHALTED && s_q.umask == UM_00 && nowr
        && ev.thread_halted |=> s_q.count == $past(s_q.count))
        else $error("count moved while halted");
    ref_cycles_a:
    assert property (plain && s_q.evsel == EV_UNHALTED && s_q.umask == UM_01
        |-> inc == b2a(ref_tick && !ev.thread_halted))
        else $error("reference cycle count wrong");
    pend_add_a:
    assert property (plain && s_q.evsel == EV_L1_PEND && s_q.umask == UM_01 && nowr
        |=> s_q.count == $past(s_q.count) + {28'h0, $past(ev.outstanding_l1_misses)})
        else $error("pending miss sum wrong");
    pend_edge_a:
    assert property (s_q.enable && s_q.edge_det && s_q.cmask == 8'h01
        && s_q.evsel == EV_L1_PEND && s_q.umask == UM_01
        |-> inc == b2a(ev.outstanding_l1_misses != 4'h0 && !s_q.cond))
        else $error("pending miss edge count wrong");
    walk_start_a:
    assert property (plain && s_q.evsel == EV_ST_TLB && s_q.umask == UM_01
        |-> inc == b2a(ev.store_walk_start))
        else $error("store walk start count wrong");
    walk_done_a:
    assert property (plain && s_q.evsel == EV_ST_TLB && s_q.umask == UM_02
        |-> inc == b2a(ev.store_walk_done))
        else $error("store walk done count wrong");
    walk_busy_a:
    assert property (plain && s_q.evsel == EV_ST_TLB && s_q.umask == UM_04
        |-> inc == b2a(ev.page_miss_handler_store_busy))
        else $error("walk busy count wrong");
    unknown_code_a:
    assert property (!dec.known && s_q.cmask == 8'h00 && nowr
        |=> s_q.count == $past(s_q.count))
        else $error("unlisted code changed count");
    code_hit_a:
    assert property (plain && s_q.evsel == EV_L2_REQ && s_q.umask == UM_CODE_HIT
        |-> inc == b2a(ev.l2_code_fetch_hit))
        else $error("code fetch hit count wrong");
    pend_level_a:
    assert property (s_q.enable && !s_q.edge_det && s_q.cmask == 8'h01
        && s_q.evsel == EV_L1_PEND && s_q.umask == UM_01 |-> inc == b2a(ev.outstanding_l1_misses != 4'h0))
        else $error("pending miss cycle count wrong");
    count_write_a:
    assert property (s_q.wr_pend && s_q.wr_ok && s_q.wr_idx == IDX_COUNT
        |=> s_q.count == $past(hwdata))
        else $error("count write did not land");
    ctrl_write_a:
    assert property (s_q.wr_pend && s_q.wr_ok && s_q.wr_idx == IDX_CTRL
        |=> s_q.evsel == $past(hwdata[7:0]) && s_q.enable == $past(hwdata[22]))
        else $error("control write did not land");
    disabled_hold_a:
    assert property (!s_q.enable && nowr
        |=> s_q.count == $past(s_q.count))
        else $error("disabled count moved");

endmodule : pes_decoder

`default_nettype wire

/* dv/pes_event_src.sv */
`timescale 1ns/1ps
`default_nettype none

// Event sources of the processor pipeline. While idle they show no events and a halted thread,
// so that even the unhalted-cycle events stay quiet between bursts.
module pes_event_src (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic active,
    output var pes_pkg::pes_events_t ev
);
    import pes_pkg::*;

    localparam int EW = $bits(pes_events_t);
    localparam pes_events_t IDLE_EV = '{thread_halted: 1'h1, default: '0};

    initial ev = IDLE_EV;

    always @(posedge core_clk) begin
        if (rst || !active) begin
            ev <= IDLE_EV;
        end else begin
            ev <= pes_events_t'(EW'($urandom));
        end
    end
endmodule : pes_event_src
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import pes_pkg::*;

    typedef struct packed {
        logic [7:0] es;
        logic [7:0] um;
        logic [7:0] cm;
        logic ed;
        logic en;
    } pes_case_t;
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] val;
    } pes_exp_t;

    localparam int NCASE = 31;
    localparam int NBURST = 40;
    localparam pes_case_t CASES [NCASE] = '{
        '{EV_L2_REQ, UM_CODE_HIT, 8'h00, 1'h0, 1'h1},
        '{EV_L2_REQ, UM_CODE_MISS, 8'h00, 1'h0, 1'h1},
        '{EV_L2_REQ, UM_CODE_ANY, 8'h00, 1'h0, 1'h1},
        '{EV_L2_REQ, UM_PF_HIT, 8'h00, 1'h0, 1'h1},
        '{EV_L2_REQ, UM_PF_MISS, 8'h00, 1'h0, 1'h1},
        '{EV_L2_REQ, UM_PF_ANY, 8'h00, 1'h0, 1'h1},
        '{EV_OWN_REQ, UM_01, 8'h00, 1'h0, 1'h1},
        '{EV_OWN_REQ, UM_04, 8'h00, 1'h0, 1'h1},
        '{EV_OWN_REQ, UM_08, 8'h00, 1'h0, 1'h1},
        '{EV_OWN_REQ, UM_0F, 8'h00, 1'h0, 1'h1},
        '{EV_L1_WB, UM_01, 8'h00, 1'h0, 1'h1},
        '{EV_L1_WB, UM_02, 8'h00, 1'h0, 1'h1},
        '{EV_L1_WB, UM_04, 8'h00, 1'h0, 1'h1},
        '{EV_L1_WB, UM_08, 8'h00, 1'h0, 1'h1},
        '{EV_L1_WB, UM_0F, 8'h00, 1'h0, 1'h1},
        '{EV_LLC, UM_LLC_REF, 8'h00, 1'h0, 1'h1},
        '{EV_LLC, UM_LLC_MISS, 8'h00, 1'h0, 1'h1},
        '{EV_UNHALTED, UM_00, 8'h00, 1'h0, 1'h1},
        '{EV_UNHALTED, UM_01, 8'h00, 1'h0, 1'h1},
        '{EV_L1_PEND, UM_01, 8'h00, 1'h0, 1'h1},
        '{EV_L1_PEND, UM_01, 8'h01, 1'h1, 1'h1},
        '{EV_L1_PEND, UM_01, 8'h01, 1'h0, 1'h1},
        '{EV_L2_REQ, UM_CODE_ANY, 8'h02, 1'h0, 1'h1},
        '{EV_ST_TLB, UM_01, 8'h00, 1'h0, 1'h1},
        '{EV_ST_TLB, UM_02, 8'h00, 1'h0, 1'h1},
        '{EV_ST_TLB, UM_04, 8'h00, 1'h0, 1'h1},
        '{EV_L2_REQ, UM_01, 8'h00, 1'h0, 1'h1},
        '{EV_LLC, UM_01, 8'h00, 1'h0, 1'h1},
        '{EV_ST_TLB, 8'h10, 8'h00, 1'h0, 1'h1},
        '{8'h00, UM_00, 8'h00, 1'h0, 1'h1},
        '{EV_L2_REQ, UM_CODE_ANY, 8'h00, 1'h0, 1'h0}
    };

    logic core_clk, rst, hsel, hwrite, hready, hreadyout, hresp, active;
    logic [31:0] haddr, hwdata, hrdata, exp_cnt;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic rd_dp, acc_on, pc;
    pes_events_t ev;
    pes_case_t cur;
    pes_exp_t exp_q[$];
    int n_mismatch, n_checks;

    // A single slave, so its ready is the bus ready.
    assign hready = hreadyout;

    initial begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    pes_event_src i_pes_event_src (.core_clk(core_clk), .rst(rst), .active(active), .ev(ev));

    pes_decoder i_pes_decoder (
        .core_clk(core_clk), .rst(rst), .ev(ev), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp)
    );

    function automatic logic [3:0] amt_f(logic [7:0] es, logic [7:0] um, pes_events_t e);
        case ({es, um})
            {EV_L2_REQ, UM_CODE_HIT}: return 4'(e.l2_code_fetch_hit);
            {EV_L2_REQ, UM_CODE_MISS}: return 4'(e.l2_code_fetch_miss);
            {EV_L2_REQ, UM_CODE_ANY}: return 4'(e.l2_code_fetch_hit) + 4'(e.l2_code_fetch_miss);
            {EV_L2_REQ, UM_PF_HIT}: return 4'(e.l2_prefetch_hit);
            {EV_L2_REQ, UM_PF_MISS}: return 4'(e.l2_prefetch_miss);
            {EV_L2_REQ, UM_PF_ANY}: return 4'(e.l2_prefetch_hit) + 4'(e.l2_prefetch_miss);
            {EV_OWN_REQ, UM_01}: return 4'(e.store_own_req_miss);
            {EV_OWN_REQ, UM_04}: return 4'(e.store_own_req_hit_e);
            {EV_OWN_REQ, UM_08}: return 4'(e.store_own_req_hit_m);
            {EV_OWN_REQ, UM_0F}: return 4'(e.store_own_req_miss) + 4'(e.store_own_req_hit_e)
                + 4'(e.store_own_req_hit_m);
            {EV_L1_WB, UM_01}: return 4'(e.wb_miss);
            {EV_L1_WB, UM_02}: return 4'(e.wb_hit_s);
            {EV_L1_WB, UM_04}: return 4'(e.wb_hit_e);
            {EV_L1_WB, UM_08}: return 4'(e.wb_hit_m);
            {EV_L1_WB, UM_0F}: return 4'(e.wb_miss) + 4'(e.wb_hit_s) + 4'(e.wb_hit_e)
                + 4'(e.wb_hit_m);
            {EV_LLC, UM_LLC_REF}: return 4'(e.last_level_ref);
            {EV_LLC, UM_LLC_MISS}: return 4'(e.last_level_miss);
            {EV_UNHALTED, UM_00}: return 4'(!e.thread_halted);
            {EV_UNHALTED, UM_01}: return 4'(!e.thread_halted);
            {EV_L1_PEND, UM_01}: return e.outstanding_l1_misses;
            {EV_ST_TLB, UM_01}: return 4'(e.store_walk_start);
            {EV_ST_TLB, UM_02}: return 4'(e.store_walk_done);
            {EV_ST_TLB, UM_04}: return 4'(e.page_miss_handler_store_busy);
            default: return 4'h0;
        endcase
    endfunction : amt_f

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (hreadyout !== 1'h1 && n < 64);
        if (hreadyout !== 1'h1) begin
            n_mismatch++;
            $display("[ERR] hreadyout expected 1 seen %b", hreadyout);
            stop_test();
        end
    endtask : wait_ready

    task automatic ahb_xfer(logic [31:0] a, logic wr, logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        wait_ready();
    endtask : ahb_xfer

    task automatic ahb_read(logic [31:0] a, logic [31:0] e);
        exp_q.push_back('{a, e});
        ahb_xfer(a, 1'h0, 32'h0);
    endtask : ahb_read

    // Reads are judged here, at the edge that ends their data phase.
    always @(posedge core_clk) begin
        pes_exp_t x;
        if (rd_dp && hready) begin
            n_checks++;
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("[ERR] read queue expected a note seen none");
            end else begin
                x = exp_q.pop_front();
                if (hrdata !== x.val || hresp !== 1'h0) begin
                    n_mismatch++;
                    $display("[ERR] hrdata at %h expected %h seen %h", x.addr, x.val, hrdata);
                end
            end
        end
        if (hready) begin
            rd_dp <= hsel && htrans[1] && !hwrite && !rst;
        end
    end

    // Reference count: ev is sampled before the edge, as the counter sees it.
    always @(posedge core_clk) begin
        logic [3:0] a;
        logic c;
        if (acc_on) begin
            a = amt_f(cur.es, cur.um, ev);
            if (cur.cm == 8'h00) begin
                exp_cnt += 32'(a);
            end else begin
                c = 8'(a) >= cur.cm;
                exp_cnt += 32'(c && (!cur.ed || !pc));
                pc = c;
            end
        end
    end

    task automatic run_case(pes_case_t c);
        logic [31:0] v;
        v = $urandom;
        ahb_xfer(OFS_COUNT, 1'h1, v);
        cur = c;
        exp_cnt = v;
        pc = 1'h0;
        ahb_xfer(OFS_CTRL, 1'h1, {c.cm, 1'h0, c.en, 3'h0, c.ed, 2'h0, c.um, c.es});
        acc_on = c.en;
        active <= 1'h1;
        repeat (NBURST) @(posedge core_clk);
        active <= 1'h0;
        // Idle edges let the last burst cycle land before counting stops.
        repeat (3) @(posedge core_clk);
        acc_on = 1'h0;
        ahb_read(OFS_COUNT, exp_cnt);
    endtask : run_case

    initial begin
        rst = 1'h1;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        active = 1'h0;
        acc_on = 1'h0;
        pc = 1'h0;
        exp_cnt = 32'h0;
        rd_dp = 1'h0;
        cur = '0;
        n_mismatch = 0;
        n_checks = 0;
        void'($urandom(32'hdc60));
        repeat (20) @(posedge core_clk);
        rst <= 1'h0;
        ahb_read(OFS_CTRL, RST_CTRL);
        ahb_read(OFS_COUNT, RST_COUNT);
        foreach (CASES[i]) begin
            run_case(CASES[i]);
        end
        ahb_xfer(OFS_CTRL, 1'h1, 32'h0140_1024);
        ahb_xfer(OFS_STATUS, 1'h1, 32'hffff_ffff);
        ahb_xfer(32'h0000_000c, 1'h1, 32'hffff_ffff);
        ahb_read(OFS_STATUS, 32'h0000_0001);
        ahb_read(32'h0000_000c, 32'h0000_0000);
        ahb_read(OFS_CTRL, 32'h0140_1024);
        @(posedge core_clk);
        if (exp_q.size() != 0) begin
            n_mismatch++;
            $display("[ERR] read queue expected 0 seen %0d", exp_q.size());
        end
        stop_test();
    end
endmodule : testbench
`default_nettype wire
